// *** include/amp_cfg_pkg.sv ***
`default_nettype none
package amp_cfg_pkg;
	// ------------------------------------------------------------
	// device register offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] REG_DIG_CTRL = 8'h02; // boost, speed, format
	localparam logic [7:0] REG_VOLUME = 8'h03; // fade and mutes
	localparam logic [7:0] REG_ANA_CFG = 8'h06; // bridge, gain, channel
	localparam logic [7:0] RST_DIG_CTRL = 8'h14;
	localparam logic [7:0] RST_VOLUME = 8'h80;
	localparam logic [7:0] RST_ANA_CFG = 8'h00; // bridge bit clear
	// field positions
	localparam int ANA_PARALLEL_BRIDGE_MODE_BIT = 7;
	localparam int ANA_GAIN_LSB = 2;
	localparam int ANA_CHSEL_BIT = 1;
	localparam int DIG_BOOST_LSB = 4;
	localparam int DIG_DS_BIT = 3;
	localparam int VOL_MUTE_R_BIT = 1;
	localparam int VOL_MUTE_L_BIT = 0;
	// control port addressing and pin modes
	localparam logic [5:0] DEV_ADDR_BASE = 6'h36; // upper six address bits
	localparam logic [1:0] SW_MODE_GAIN = 2'h3; // both gain pins high
	localparam logic [1:0] HW_BOOST = 2'h1; // fixed boost step in pin mode
	localparam logic [3:0] ACK_SLOT = 4'h8; // bit count at ack clock
	localparam logic [3:0] BYTE_DONE = 4'h9;
	// accepted clock ratios, multiples of fs
	localparam logic [9:0] MCLK_128 = 10'h080;
	localparam logic [9:0] MCLK_192 = 10'h0c0;
	localparam logic [9:0] MCLK_256 = 10'h100;
	localparam logic [9:0] MCLK_384 = 10'h180;
	localparam logic [9:0] MCLK_512 = 10'h200;
	localparam logic [6:0] SCLK_32 = 7'h20;
	localparam logic [6:0] SCLK_48 = 7'h30;
	localparam logic [6:0] SCLK_64 = 7'h40;
	// ------------------------------------------------------------
	// host controller register map and timing
	// ------------------------------------------------------------
	localparam logic [3:0] HREG_CMD = 4'h0;
	localparam logic [3:0] HREG_CTRL = 4'h4;
	localparam logic [3:0] HREG_STATUS = 4'h8;
	localparam logic [3:0] RST_HCTRL = 4'h3; // software mode, bridge low
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int CLK_HZ = 20000000;
	localparam int SCL_HZ = 100000; // control port bit rate
	localparam int QTR_CYCLES = CLK_HZ / (4 * SCL_HZ); // quarter bit
endpackage : amp_cfg_pkg
`default_nettype wire

// *** include/amp_link_if.sv ***
`default_nettype none
interface amp_link_if;
	logic [1:0] gain_sel; // mode and gain pins
	logic scl; // bridge pin or control clock
	logic sda_h_o; // host data out, always low
	logic sda_h_oe; // host pulls data low
	logic sda_d_o; // device data out, always low
	logic sda_d_oe; // device pulls data low
	logic sda; // resolved open-drain level
	// wired-and with pull-up
	assign sda = !((sda_h_oe && !sda_h_o) || (sda_d_oe && !sda_d_o));
	modport host(output gain_sel, output scl, output sda_h_o, output sda_h_oe, input sda);
	modport device(input gain_sel, input scl, input sda, output sda_d_o, output sda_d_oe);
endinterface : amp_link_if
`default_nettype wire

// *** verilog/amp_tick_gen.sv ***
`default_nettype none
module amp_tick_gen #(
	parameter int DIV = amp_cfg_pkg::QTR_CYCLES
) (
	input wire logic core_clk,
	input wire logic rst_n,
	output logic tick
);
	// ------------------------------------------------------------
	// divider giving one-cycle enable pulses
	// ------------------------------------------------------------
	logic [15:0] cnt_r; // cycles since last pulse
	logic [15:0] cnt_nxt;

	// next count, wrap at divide value
	always_comb begin
		if (cnt_r == 16'(DIV - 1)) begin
			cnt_nxt = 16'h0000;
		end else begin
			cnt_nxt = cnt_r + 16'h0001;
		end
	end

	// count register
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			cnt_r <= 16'h0000;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	assign tick = (cnt_r == 16'(DIV - 1));
endmodule : amp_tick_gen
`default_nettype wire

// *** verilog/amp_cfg_host.sv ***
`default_nettype none
module amp_cfg_host (
	input wire logic core_clk,
	input wire logic rst_n,
	amp_link_if.host link,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	typedef enum logic [1:0] {H_IDLE = 2'h0, H_START = 2'h1, H_BIT = 2'h3, H_STOP = 2'h2} hst_e;
	hst_e st_r, st_nxt; // bus engine state
	logic [1:0] ph_r, ph_nxt; // quarter of bit
	logic [3:0] bit_r, bit_nxt; // bit within byte, 8 is ack
	logic [1:0] idx_r, idx_nxt; // byte within transfer
	logic [7:0] tx_r, tx_nxt; // bits going out
	logic [7:0] rx_r, rx_nxt; // bits coming in
	logic scl_r, scl_nxt; // driven clock
	logic oe_r, oe_nxt; // pulling data low
	logic aw_r, aw_nxt, w_r, w_nxt; // held address and data
	logic [3:0] awa_r, awa_nxt;
	logic [31:0] wd_r, wd_nxt;
	logic [3:0] ws_r, ws_nxt;
	logic bv_r, bv_nxt, rv_r, rv_nxt;
	logic [1:0] br_r, br_nxt, rr_r, rr_nxt;
	logic [31:0] rd_r, rd_nxt;
	logic [3:0] ctrl_r, ctrl_nxt; // gain pins, bridge level, strap copy
	logic rdop_r, rdop_nxt; // command is a read
	logic [7:0] reg_r, reg_nxt, dat_r, dat_nxt; // register and data bytes
	logic nack_r, nack_nxt; // device refused a byte
	logic [7:0] rby_r, rby_nxt; // last byte read
	logic tick;
	logic [31:0] cmd_w, mask, status_w;

	amp_tick_gen #(.DIV(amp_cfg_pkg::QTR_CYCLES)) u_tick (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.tick(tick)
	);

	// byte to send at each position of a transfer
	function automatic logic [7:0] byte_f(input logic [1:0] i, input logic rd,
			input logic sel, input logic [7:0] ra, input logic [7:0] d);
		logic [7:0] b;
		b = 8'hff; // released for read data
		unique case (i)
			2'h0: b = {amp_cfg_pkg::DEV_ADDR_BASE, sel, 1'b0};
			2'h1: b = ra;
			2'h2: b = rd ? {amp_cfg_pkg::DEV_ADDR_BASE, sel, 1'b1} : d;
			2'h3: b = 8'hff;
		endcase
		return b;
	endfunction : byte_f

	// ------------------------------------------------------------
	// bus slave and control-port engine
	// ------------------------------------------------------------
	always_comb begin
		mask = {{8{ws_r[3]}}, {8{ws_r[2]}}, {8{ws_r[1]}}, {8{ws_r[0]}}};
		cmd_w = {8'h00, dat_r, reg_r, 6'h00, rdop_r, 1'b0};
		status_w = {16'h0000, rby_r, 6'h00, nack_r, st_r != H_IDLE};
		aw_nxt = aw_r; w_nxt = w_r; awa_nxt = awa_r; wd_nxt = wd_r; ws_nxt = ws_r;
		bv_nxt = bv_r; br_nxt = br_r; rv_nxt = rv_r; rr_nxt = rr_r; rd_nxt = rd_r;
		ctrl_nxt = ctrl_r; rdop_nxt = rdop_r; reg_nxt = reg_r; dat_nxt = dat_r;
		st_nxt = st_r; ph_nxt = ph_r; bit_nxt = bit_r; idx_nxt = idx_r;
		tx_nxt = tx_r; rx_nxt = rx_r; scl_nxt = scl_r; oe_nxt = oe_r;
		nack_nxt = nack_r; rby_nxt = rby_r;
		// take address and data in either order
		if (s_axi_awvalid && s_axi_awready) begin
			aw_nxt = 1'b1; awa_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_nxt = 1'b1; wd_nxt = s_axi_wdata; ws_nxt = s_axi_wstrb;
		end
		if (s_axi_bvalid && s_axi_bready) begin
			bv_nxt = 1'b0;
		end
		// both held: perform write, answer next cycle
		if (aw_r && w_r && !bv_r) begin
			aw_nxt = 1'b0; w_nxt = 1'b0; bv_nxt = 1'b1; br_nxt = amp_cfg_pkg::RESP_OKAY;
			unique case (awa_r)
				amp_cfg_pkg::HREG_CMD: begin
					{dat_nxt, reg_nxt} = 16'((((cmd_w & ~mask) | (wd_r & mask)) >> 8));
					if (ws_r[0]) begin
						rdop_nxt = wd_r[1];
					end
					// start only when idle, otherwise ignored
					if (ws_r[0] && wd_r[0] && st_r == H_IDLE) begin
						st_nxt = H_START; ph_nxt = 2'h0; idx_nxt = 2'h0; nack_nxt = 1'b0;
						rdop_nxt = wd_r[1];
					end
				end
				amp_cfg_pkg::HREG_CTRL: if (ws_r[0]) ctrl_nxt = wd_r[3:0]; // R9 R11
				amp_cfg_pkg::HREG_STATUS: ;
				default: br_nxt = amp_cfg_pkg::RESP_SLVERR;
			endcase
		end
		// read answer one cycle after address
		if (s_axi_rvalid && s_axi_rready) begin
			rv_nxt = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rv_nxt = 1'b1; rr_nxt = amp_cfg_pkg::RESP_OKAY;
			unique case (s_axi_araddr)
				amp_cfg_pkg::HREG_CMD: rd_nxt = cmd_w;
				amp_cfg_pkg::HREG_CTRL: rd_nxt = {28'h0000000, ctrl_r};
				amp_cfg_pkg::HREG_STATUS: rd_nxt = status_w;
				default: begin
					rd_nxt = 32'h00000000; rr_nxt = amp_cfg_pkg::RESP_SLVERR;
				end
			endcase
		end
		// engine moves one quarter bit per tick
		if (tick && st_r != H_IDLE) begin
			ph_nxt = ph_r + 2'h1;
			unique case (st_r)
				H_START: begin // start or repeated start
					unique case (ph_r)
						2'h0: oe_nxt = 1'b0;
						2'h1: scl_nxt = 1'b1;
						2'h2: oe_nxt = 1'b1;
						2'h3: begin
							scl_nxt = 1'b0; st_nxt = H_BIT; bit_nxt = 4'h0;
							tx_nxt = byte_f(idx_r, rdop_r, ctrl_r[3], reg_r, dat_r);
						end
					endcase
				end
				H_BIT: begin
					unique case (ph_r)
						2'h0: oe_nxt = (bit_r < amp_cfg_pkg::ACK_SLOT) ? !tx_r[7] : 1'b0;
						2'h1: scl_nxt = 1'b1;
						2'h2: begin
							if (bit_r < amp_cfg_pkg::ACK_SLOT) begin
								rx_nxt = {rx_r[6:0], link.sda};
							end else if (idx_r != 2'h3 && link.sda) begin
								nack_nxt = 1'b1;
							end
						end
						2'h3: begin
							scl_nxt = 1'b0; tx_nxt = {tx_r[6:0], 1'b1}; bit_nxt = bit_r + 4'h1;
							if (bit_r == amp_cfg_pkg::ACK_SLOT) begin
								bit_nxt = 4'h0; idx_nxt = idx_r + 2'h1;
								// last byte: index 2 for a write, 3 for a read
								if (nack_r || idx_r == {1'b1, rdop_r}) begin
									st_nxt = H_STOP;
								end else if (rdop_r && idx_r == 2'h1) begin
									st_nxt = H_START;
								end else begin
									tx_nxt = byte_f(idx_r + 2'h1, rdop_r, ctrl_r[3], reg_r, dat_r);
								end
							end
						end
					endcase
				end
				H_STOP: begin
					unique case (ph_r)
						2'h0: oe_nxt = 1'b1;
						2'h1: scl_nxt = 1'b1;
						2'h2: oe_nxt = 1'b0;
						2'h3: begin
							st_nxt = H_IDLE;
							if (rdop_r && !nack_r) begin
								rby_nxt = rx_r;
							end
						end
					endcase
				end
				H_IDLE: ;
			endcase
		end
	end

	// register all state
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= H_IDLE; ph_r <= 2'h0; bit_r <= 4'h0; idx_r <= 2'h0;
			tx_r <= 8'hff; rx_r <= 8'h00; scl_r <= 1'b1; oe_r <= 1'b0;
			aw_r <= 1'b0; w_r <= 1'b0; awa_r <= 4'h0; wd_r <= 32'h00000000; ws_r <= 4'h0;
			bv_r <= 1'b0; br_r <= 2'h0; rv_r <= 1'b0; rr_r <= 2'h0; rd_r <= 32'h00000000;
			ctrl_r <= amp_cfg_pkg::RST_HCTRL; rdop_r <= 1'b0; reg_r <= 8'h00; dat_r <= 8'h00;
			nack_r <= 1'b0; rby_r <= 8'h00;
		end else begin
			st_r <= st_nxt; ph_r <= ph_nxt; bit_r <= bit_nxt; idx_r <= idx_nxt;
			tx_r <= tx_nxt; rx_r <= rx_nxt; scl_r <= scl_nxt; oe_r <= oe_nxt;
			aw_r <= aw_nxt; w_r <= w_nxt; awa_r <= awa_nxt; wd_r <= wd_nxt; ws_r <= ws_nxt;
			bv_r <= bv_nxt; br_r <= br_nxt; rv_r <= rv_nxt; rr_r <= rr_nxt; rd_r <= rd_nxt;
			ctrl_r <= ctrl_nxt; rdop_r <= rdop_nxt; reg_r <= reg_nxt; dat_r <= dat_nxt;
			nack_r <= nack_nxt; rby_r <= rby_nxt;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign s_axi_awready = !aw_r && !bv_r;
	assign s_axi_wready = !w_r && !bv_r;
	assign s_axi_bvalid = bv_r;
	assign s_axi_bresp = br_r;
	assign s_axi_arready = !rv_r;
	assign s_axi_rvalid = rv_r;
	assign s_axi_rdata = rd_r;
	assign s_axi_rresp = rr_r;
	assign link.gain_sel = ctrl_r[1:0]; // R12
	// pin carries bridge level in pin mode, clock in software mode
	assign link.scl = (ctrl_r[1:0] == amp_cfg_pkg::SW_MODE_GAIN) ? scl_r : ctrl_r[2]; // R12
	assign link.sda_h_o = 1'b0;
	assign link.sda_h_oe = oe_r;
endmodule : amp_cfg_host
`default_nettype wire

// *** verilog/amp_cfg_device.sv ***
`default_nettype none
// Function
// R1 - double speed: 128/192/256 mclk, 32/48/64 sclk
// R2 - analog config bit 7 selects mono bridge
// R3 - bridge bit resets clear, stereo after reset
// R4 - analog config bit 1 picks bridge input channel
// R5 - bridge via pin or register by mode
// R6 - total gain is digital plus analog step
// R7 - software mode gains come from registers
// R8 - boost independent of volume and mutes
// R9 - host sets boost before unmute, then leaves
// R10 - analog gain in bits 3 to 2
// R11 - host limits clipping with clipper settings
// R12 - both gain pins high selects control port
// R13 - channel select zero left, only while bridged
module amp_cfg_device #(
	parameter int SAMPLE_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	amp_link_if.device link,
	input wire logic adr_strap,
	input wire logic [SAMPLE_W-1:0] audio_left,
	input wire logic [SAMPLE_W-1:0] audio_right,
	input wire logic audio_valid,
	input wire logic [9:0] mclk_ratio,
	input wire logic [6:0] sclk_ratio,
	output logic [SAMPLE_W-1:0] spk_a,
	output logic [SAMPLE_W-1:0] spk_b,
	output logic spk_valid,
	output logic parallel_bridge_mode,
	output logic software_mode,
	output logic double_speed,
	output logic clock_ok,
	output logic [1:0] analog_path_gain,
	output logic [1:0] digital_path_gain,
	output logic [2:0] total_gain_step
);
	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		D_IDLE = 3'h0, // waiting for start
		D_ADDR = 3'h1, // device address byte
		D_REG = 3'h3, // register pointer byte
		D_WDATA = 3'h2, // data bytes written
		D_RDATA = 3'h6 // data bytes read back
	} dst_e;
	dst_e st_r, st_nxt;
	logic [3:0] cnt_r, cnt_nxt; // clock rises seen in byte
	logic [7:0] sh_r, sh_nxt; // shift register
	logic [7:0] ptr_r, ptr_nxt; // register pointer
	logic oe_r, oe_nxt; // pulling data low
	logic scl_q_r, sda_q_r; // previous line levels
	logic strap_done_r, adr_bit_r; // address strap capture
	logic [7:0] dig_r, dig_nxt; // digital control register
	logic [7:0] vol_r, vol_nxt; // volume register
	logic [7:0] ana_r, ana_nxt; // analog config register
	logic start_c, stop_c, rise_c, fall_c; // line events
	logic sw_c; // software control mode
	logic parallel_bridge_mode_c, ds_c, ok_c, mok_c, sok_c;
	logic [1:0] again_c, boost_c;
	logic [SAMPLE_W-1:0] a_nxt, b_nxt, src_c;
	logic v_nxt, parallel_bridge_mode_nxt, ds_nxt, okr_nxt;
	logic [1:0] ag_nxt, dg_nxt;
	logic [2:0] tg_nxt;

	// register readback
	function automatic logic [7:0] rd_f(input logic [7:0] a, input logic [7:0] d,
			input logic [7:0] v, input logic [7:0] n);
		logic [7:0] r;
		r = 8'h00; // unmapped reads zero
		case (a)
			amp_cfg_pkg::REG_DIG_CTRL: r = d;
			amp_cfg_pkg::REG_VOLUME: r = v;
			amp_cfg_pkg::REG_ANA_CFG: r = n;
			default: r = 8'h00;
		endcase
		return r;
	endfunction : rd_f

	// boost by 6 dB steps with saturation
	function automatic logic [SAMPLE_W-1:0] boost_f(input logic [SAMPLE_W-1:0] s,
			input logic [1:0] k);
		logic [SAMPLE_W+2:0] w;
		logic [SAMPLE_W-1:0] o;
		w = {{3{s[SAMPLE_W-1]}}, s} << k;
		o = w[SAMPLE_W-1:0];
		if (!(&w[SAMPLE_W+2:SAMPLE_W-1]) && (|w[SAMPLE_W+2:SAMPLE_W-1])) begin
			o = {w[SAMPLE_W+2], {(SAMPLE_W-1){!w[SAMPLE_W+2]}}};
		end
		return o;
	endfunction : boost_f

	// ------------------------------------------------------------
	// line events and mode
	// ------------------------------------------------------------
	assign sw_c = (link.gain_sel == amp_cfg_pkg::SW_MODE_GAIN); // R12
	assign start_c = link.scl && scl_q_r && sda_q_r && !link.sda;
	assign stop_c = link.scl && scl_q_r && !sda_q_r && link.sda;
	assign rise_c = link.scl && !scl_q_r;
	assign fall_c = !link.scl && scl_q_r;

	// line history and address strap, caught after reset release
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			scl_q_r <= 1'b1;
			sda_q_r <= 1'b1;
			strap_done_r <= 1'b0;
			adr_bit_r <= 1'b0;
		end else begin
			scl_q_r <= link.scl;
			sda_q_r <= link.sda;
			strap_done_r <= 1'b1;
			if (!strap_done_r) begin
				adr_bit_r <= adr_strap;
			end
		end
	end

	// ------------------------------------------------------------
	// control port slave and registers
	// ------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		ptr_nxt = ptr_r;
		oe_nxt = oe_r;
		dig_nxt = dig_r;
		vol_nxt = vol_r;
		ana_nxt = ana_r;
		if (!sw_c) begin
			// pins in gain mode: port unused
			st_nxt = D_IDLE;
			oe_nxt = 1'b0;
		end else if (start_c) begin
			// start or repeated start
			st_nxt = D_ADDR;
			cnt_nxt = 4'h0;
			oe_nxt = 1'b0;
		end else if (stop_c) begin
			st_nxt = D_IDLE;
			oe_nxt = 1'b0;
		end else if (st_r != D_IDLE && rise_c) begin
			// sample on rising clock
			if (cnt_r < amp_cfg_pkg::ACK_SLOT && st_r != D_RDATA) begin
				sh_nxt = {sh_r[6:0], link.sda};
			end
			if (cnt_r == amp_cfg_pkg::ACK_SLOT && st_r == D_RDATA && link.sda) begin
				st_nxt = D_IDLE; // master nack ends read
			end
			cnt_nxt = cnt_r + 4'h1;
		end else if (st_r != D_IDLE && fall_c) begin
			if (cnt_r == amp_cfg_pkg::ACK_SLOT) begin
				// ack slot opens
				unique case (st_r)
					D_ADDR: begin
						if (sh_r[7:1] == {amp_cfg_pkg::DEV_ADDR_BASE, adr_bit_r}) begin
							oe_nxt = 1'b1;
						end else begin
							st_nxt = D_IDLE; // not ours
						end
					end
					D_RDATA: oe_nxt = 1'b0; // master answers
					D_REG: oe_nxt = 1'b1;
					D_WDATA: begin
						oe_nxt = 1'b1;
						// software-mode writes set the addressed gain or volume register
						case (ptr_r)
							amp_cfg_pkg::REG_DIG_CTRL: dig_nxt = sh_r; // R7 R8
							amp_cfg_pkg::REG_VOLUME: vol_nxt = sh_r; // R8
							amp_cfg_pkg::REG_ANA_CFG: ana_nxt = sh_r; // R2 R4 R7 R10
							default: ;
						endcase
					end
					D_IDLE: ;
				endcase
			end else if (cnt_r == amp_cfg_pkg::BYTE_DONE) begin
				// ack slot closes, next byte
				cnt_nxt = 4'h0;
				oe_nxt = 1'b0;
				unique case (st_r)
					D_ADDR: begin
						if (sh_r[0]) begin
							st_nxt = D_RDATA;
							sh_nxt = rd_f(ptr_r, dig_r, vol_r, ana_r);
							oe_nxt = !sh_nxt[7];
						end else begin
							st_nxt = D_REG;
						end
					end
					D_REG: begin
						ptr_nxt = sh_r;
						st_nxt = D_WDATA;
					end
					D_WDATA: ptr_nxt = ptr_r + 8'h01;
					D_RDATA: begin
						ptr_nxt = ptr_r + 8'h01;
						sh_nxt = rd_f(ptr_r + 8'h01, dig_r, vol_r, ana_r);
						oe_nxt = !sh_nxt[7];
					end
					D_IDLE: ;
				endcase
			end else if (st_r == D_RDATA) begin
				// next read bit, msb first
				sh_nxt = {sh_r[6:0], 1'b1};
				oe_nxt = !sh_nxt[7];
			end
		end
	end

	// slave and register flops
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= D_IDLE;
			cnt_r <= 4'h0;
			sh_r <= 8'h00;
			ptr_r <= 8'h00;
			oe_r <= 1'b0;
			dig_r <= amp_cfg_pkg::RST_DIG_CTRL;
			vol_r <= amp_cfg_pkg::RST_VOLUME;
			ana_r <= amp_cfg_pkg::RST_ANA_CFG; // R3
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			ptr_r <= ptr_nxt;
			oe_r <= oe_nxt;
			dig_r <= dig_nxt;
			vol_r <= vol_nxt;
			ana_r <= ana_nxt;
		end
	end

	assign link.sda_d_o = 1'b0;
	assign link.sda_d_oe = oe_r;

	// ------------------------------------------------------------
	// effective configuration and audio path
	// ------------------------------------------------------------
	always_comb begin
		// bridge from pin level or register bit
		parallel_bridge_mode_c = sw_c ? ana_r[amp_cfg_pkg::ANA_PARALLEL_BRIDGE_MODE_BIT] : link.scl; // R2 R5
		again_c = sw_c ? ana_r[amp_cfg_pkg::ANA_GAIN_LSB +: 2] : link.gain_sel; // R7 R10
		boost_c = sw_c ? dig_r[amp_cfg_pkg::DIG_BOOST_LSB +: 2] : amp_cfg_pkg::HW_BOOST; // R7
		ds_c = sw_c && dig_r[amp_cfg_pkg::DIG_DS_BIT];
		// accepted ratio sets
		sok_c = (sclk_ratio == amp_cfg_pkg::SCLK_32) || (sclk_ratio == amp_cfg_pkg::SCLK_48)
			|| (sclk_ratio == amp_cfg_pkg::SCLK_64); // R1
		mok_c = (mclk_ratio == amp_cfg_pkg::MCLK_128) || (mclk_ratio == amp_cfg_pkg::MCLK_192)
			|| (mclk_ratio == amp_cfg_pkg::MCLK_256); // R1
		if (!ds_c) begin
			mok_c = mok_c || (mclk_ratio == amp_cfg_pkg::MCLK_384)
				|| (mclk_ratio == amp_cfg_pkg::MCLK_512);
		end
		ok_c = mok_c && sok_c; // R1
		// channel select only matters while bridged
		src_c = ana_r[amp_cfg_pkg::ANA_CHSEL_BIT] ? audio_right : audio_left; // R4 R13
		a_nxt = spk_a;
		b_nxt = spk_b;
		v_nxt = audio_valid;
		if (audio_valid) begin
			// boost applied before mutes, each untouched by the other
			a_nxt = boost_f(parallel_bridge_mode_c ? src_c : audio_left, boost_c); // R8 R13
			b_nxt = boost_f(parallel_bridge_mode_c ? src_c : audio_right, boost_c); // R2 R13
			if (vol_r[amp_cfg_pkg::VOL_MUTE_L_BIT]) begin
				a_nxt = '0;
			end
			if (vol_r[amp_cfg_pkg::VOL_MUTE_R_BIT]) begin
				b_nxt = '0;
			end
		end
		parallel_bridge_mode_nxt = parallel_bridge_mode_c;
		ds_nxt = ds_c;
		okr_nxt = ok_c;
		ag_nxt = again_c;
		dg_nxt = boost_c;
		tg_nxt = {1'b0, boost_c} + {1'b0, again_c}; // R6
	end

	// output flops
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			spk_a <= '0;
			spk_b <= '0;
			spk_valid <= 1'b0;
			parallel_bridge_mode <= 1'b0;
			software_mode <= 1'b0;
			double_speed <= 1'b0;
			clock_ok <= 1'b0;
			analog_path_gain <= 2'h0;
			digital_path_gain <= 2'h0;
			total_gain_step <= 3'h0;
		end else begin
			spk_a <= a_nxt;
			spk_b <= b_nxt;
			spk_valid <= v_nxt;
			parallel_bridge_mode <= parallel_bridge_mode_nxt;
			software_mode <= sw_c;
			double_speed <= ds_nxt;
			clock_ok <= okr_nxt;
			analog_path_gain <= ag_nxt;
			digital_path_gain <= dg_nxt;
			total_gain_step <= tg_nxt;
		end
	end
endmodule : amp_cfg_device
`default_nettype wire

// *** tb/amp_link_chk.sv ***
`default_nettype none
module amp_link_chk #(
	parameter int SAMPLE_W = 16
) (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic [1:0] gain_sel,
	input wire logic scl,
	input wire logic sda_d_oe,
	input wire logic parallel_bridge_mode,
	input wire logic software_mode,
	input wire logic [1:0] analog_path_gain,
	input wire logic [1:0] digital_path_gain,
	input wire logic [2:0] total_gain_step,
	input wire logic audio_valid,
	input wire logic spk_valid,
	input wire logic [SAMPLE_W-1:0] spk_a,
	input wire logic [SAMPLE_W-1:0] spk_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------------------------------
	// mode, gain and audio checks
	// ----------------------------------------
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);
	chk_bridge_reset: assert property ($rose(rst_n) |-> !parallel_bridge_mode)
		else $error("bridge set after reset");
	chk_gain_sum: assert property (total_gain_step == analog_path_gain + digital_path_gain)
		else $error("total gain not sum");
	chk_sw_select: assert property (gain_sel == 2'h3 |=> software_mode)
		else $error("software mode missed");
	chk_pin_gain: assert property (gain_sel != 2'h3 |=> analog_path_gain == $past(gain_sel))
		else $error("pin gain wrong");
	chk_pin_bridge: assert property (gain_sel != 2'h3 |=> parallel_bridge_mode == $past(scl))
		else $error("pin bridge wrong");
	chk_mono_copy: assert property (spk_valid && parallel_bridge_mode |-> spk_a == spk_b)
		else $error("bridged outputs differ");
	chk_audio_lat: assert property (audio_valid |=> spk_valid)
		else $error("audio pulse lost");
	chk_port_quiet: assert property (!software_mode |-> !sda_d_oe)
		else $error("data pulled in pin mode");
endmodule : amp_link_chk
`default_nettype wire

// *** tb/amp_software_mode_config_tb_top.sv ***
`default_nettype none
module amp_software_mode_config_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	`define CK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_total++; \
		$display("FAIL t=%0t got %h exp %h", $time, (g), (e)); end end
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic core_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp, analog_path_gain, digital_path_gain;
	logic adr_strap = 1'b0; // address bit low
	logic [15:0] audio_left = 16'h0, audio_right = 16'h0, spk_a, spk_b;
	logic audio_valid = 1'b0;
	logic [9:0] mclk_ratio = 10'h100;
	logic [6:0] sclk_ratio = 7'h40;
	logic spk_valid, parallel_bridge_mode, software_mode, double_speed, clock_ok;
	logic [2:0] total_gain_step;
	int err_total = 0, samples_checked = 0;
	always #25 core_clk = ~core_clk;
	amp_link_if amp_link_if_i();
	amp_cfg_host amp_cfg_host_i (.link(amp_link_if_i), .*);
	amp_cfg_device #(.SAMPLE_W(16)) amp_cfg_device_i (.link(amp_link_if_i), .*);
	amp_link_chk #(.SAMPLE_W(16)) amp_link_chk_i (.gain_sel(amp_link_if_i.gain_sel),
		.scl(amp_link_if_i.scl), .sda_d_oe(amp_link_if_i.sda_d_oe), .*);
	// ----------------------------------------
	// bus tasks, handshakes seen before the edge
	// ----------------------------------------
	task automatic report_and_stop(input int hang);
		err_total += hang;
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : report_and_stop
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		logic aw, w, b;
		n = 0;
		b = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b && n < 100) begin
			@(negedge core_clk);
			aw = s_axi_awvalid && s_axi_awready;
			w = s_axi_wvalid && s_axi_wready;
			b = s_axi_bvalid;
			resp = s_axi_bresp;
			@(posedge core_clk);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			n++;
		end
		s_axi_bready <= 1'b0;
		if (!b) report_and_stop(1);
	endtask : wr
	task automatic rd(input logic [3:0] a);
		int n;
		logic ar, r;
		n = 0;
		r = 1'b0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r && n < 100) begin
			@(negedge core_clk);
			ar = s_axi_arvalid && s_axi_arready;
			r = s_axi_rvalid;
			v = s_axi_rdata;
			@(posedge core_clk);
			if (ar) s_axi_arvalid <= 1'b0;
			n++;
		end
		s_axi_rready <= 1'b0;
		if (!r) report_and_stop(1);
	endtask : rd
	// one device register access, polled to completion
	task automatic dev(input logic rdn, input logic [7:0] ra, input logic [7:0] d);
		int n;
		n = 0;
		wr(amp_cfg_pkg::HREG_CMD, {8'h00, d, ra, 6'h00, rdn, 1'b1});
		v = 32'h1;
		while (v[0] && n < 9000) begin
			rd(amp_cfg_pkg::HREG_STATUS);
			n++;
		end
		if (v[0]) report_and_stop(1);
		@(negedge core_clk);
	endtask : dev
	task automatic snd(input logic [15:0] l, input logic [15:0] r, input logic [15:0] e);
		@(posedge core_clk);
		audio_left <= l;
		audio_right <= r;
		audio_valid <= 1'b1;
		@(posedge core_clk);
		audio_valid <= 1'b0;
		@(negedge core_clk);
		`CK(spk_valid, 1'b1)
		`CK(spk_a, e)
		`CK(spk_b, e)
	endtask : snd
	// ----------------------------------------
	// test sequence
	// ----------------------------------------
	initial begin
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		dev(1'b1, amp_cfg_pkg::REG_ANA_CFG, 8'h00);
		`CK(v[15:8], 8'h00)
		`CK(parallel_bridge_mode, 1'b0)
		$display("test reset done");
		dev(1'b0, amp_cfg_pkg::REG_ANA_CFG, 8'h88);
		`CK(parallel_bridge_mode, 1'b1)
		`CK(analog_path_gain, 2'h2)
		`CK(total_gain_step, 3'h3)
		snd(16'h0100, 16'h0200, 16'h0200);
		dev(1'b0, amp_cfg_pkg::REG_ANA_CFG, 8'h8a);
		snd(16'h0100, 16'h0200, 16'h0400);
		dev(1'b1, amp_cfg_pkg::REG_ANA_CFG, 8'h00);
		`CK(v[15:8], 8'h8a)
		$display("test bridge done");
		dev(1'b0, amp_cfg_pkg::REG_DIG_CTRL, 8'h3c);
		`CK(digital_path_gain, 2'h3)
		`CK(double_speed, 1'b1)
		`CK(clock_ok, 1'b1)
		@(posedge core_clk);
		mclk_ratio <= amp_cfg_pkg::MCLK_384;
		repeat (3) @(negedge core_clk);
		`CK(clock_ok, 1'b0)
		@(posedge core_clk);
		mclk_ratio <= amp_cfg_pkg::MCLK_128;
		sclk_ratio <= amp_cfg_pkg::SCLK_48;
		dev(1'b0, amp_cfg_pkg::REG_VOLUME, 8'h00);
		`CK(clock_ok, 1'b1)
		`CK(digital_path_gain, 2'h3)
		snd(16'h0100, 16'h0200, 16'h1000);
		$display("test gain done");
		wr(4'hc, 32'h0);
		`CK(resp, amp_cfg_pkg::RESP_SLVERR)
		wr(amp_cfg_pkg::HREG_CTRL, 32'h1);
		repeat (3) @(negedge core_clk);
		`CK(software_mode, 1'b0)
		`CK(parallel_bridge_mode, 1'b0)
		`CK(analog_path_gain, 2'h1)
		$display("test pin mode done");
		report_and_stop(0);
	end
endmodule : amp_software_mode_config_tb_top
`default_nettype wire
